// file: rtl/power_save_config_pkg.sv
// constants shared by the serial port power-save gating block
// assumes a 100 MHz system clock and an active-low on-state for the modem lines
package power_save_config_pkg;

    // power-save configuration codes
    localparam logic [1:0] POWER_SAVE_CONFIG_CFG_OFF = 2'h0;
    localparam logic [1:0] POWER_SAVE_CONFIG_CFG_CYCLIC = 2'h1;
    localparam logic [1:0] POWER_SAVE_CONFIG_CFG_RTS = 2'h2;
    localparam logic [1:0] POWER_SAVE_CONFIG_CFG_DTR = 2'h3;
    localparam logic [1:0] POWER_SAVE_CONFIG_CFG_RESET = POWER_SAVE_CONFIG_CFG_OFF;

    // modem line indices inside the synchroniser
    localparam int POWER_SAVE_CONFIG_LINE_RTS = 0;
    localparam int POWER_SAVE_CONFIG_LINE_DTR = 1;
    localparam int POWER_SAVE_CONFIG_LINES = 2;

    // clock rate
    localparam longint POWER_SAVE_CONFIG_CLK_MHZ = 100;

    // times in their own units, as given
    localparam longint POWER_SAVE_CONFIG_WAKE_TIME_US = 20000;
    localparam longint POWER_SAVE_CONFIG_WINDOW_TIME_US = 20000;
    localparam longint POWER_SAVE_CONFIG_OFF_TIME_MS = 2500;
    localparam longint POWER_SAVE_CONFIG_FRAME_TIME_NS = 4615000;
    localparam longint POWER_SAVE_CONFIG_INACT_FRAMES = 2000;

    // derived cycle counts
    localparam longint POWER_SAVE_CONFIG_WAKE_CYC = POWER_SAVE_CONFIG_WAKE_TIME_US * POWER_SAVE_CONFIG_CLK_MHZ;
    localparam longint POWER_SAVE_CONFIG_WINDOW_CYC = POWER_SAVE_CONFIG_WINDOW_TIME_US * POWER_SAVE_CONFIG_CLK_MHZ;
    localparam longint POWER_SAVE_CONFIG_OFF_CYC = POWER_SAVE_CONFIG_OFF_TIME_MS * 1000 * POWER_SAVE_CONFIG_CLK_MHZ;
    localparam longint POWER_SAVE_CONFIG_INACT_CYC = (POWER_SAVE_CONFIG_INACT_FRAMES * POWER_SAVE_CONFIG_FRAME_TIME_NS * POWER_SAVE_CONFIG_CLK_MHZ) / 1000;

    // reset values
    localparam logic [31:0] POWER_SAVE_CONFIG_TIMER_RESET = 32'h0000_0000;
    localparam logic [7:0] POWER_SAVE_CONFIG_DATA_RESET = 8'h00;
    localparam logic [1:0] POWER_SAVE_CONFIG_LINE_RESET = 2'h0;

    typedef enum logic [1:0] {
        POWER_SAVE_CONFIG_ST_ON,
        POWER_SAVE_CONFIG_ST_OFF,
        POWER_SAVE_CONFIG_ST_WAKE
    } power_save_config_state_t;

endpackage

// file: rtl/power_save_config_line_if.sv
// carries synchronised modem control line state between the synchroniser and the gate
// assumes both ends run on sys_clk
`timescale 1ns/100ps
interface power_save_config_line_if;
    logic [1:0] line_on;
    logic [1:0] line_rise;

    modport src (
        output line_on,
        output line_rise
    );

    modport dst (
        input line_on,
        input line_rise
    );
endinterface

// file: rtl/power_save_config_line_sync.sv
// two-stage synchroniser and off-to-on edge detector for the rts and dtr pins
// assumes pins are active low (on = low level) and asynchronous to sys_clk
`timescale 1ns/100ps
module power_save_config_line_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic rts_n,
    input wire logic dtr_n,
    power_save_config_line_if.src lines
);

    logic [1:0] pin_on;
    logic [1:0] meta_q;
    logic [1:0] meta_d;
    logic [1:0] sync_q;
    logic [1:0] sync_d;
    logic [1:0] prev_q;
    logic [1:0] prev_d;
    logic [1:0] rise_q;
    logic [1:0] rise_d;

    assign pin_on[power_save_config_pkg::POWER_SAVE_CONFIG_LINE_RTS] = ~rts_n;
    assign pin_on[power_save_config_pkg::POWER_SAVE_CONFIG_LINE_DTR] = ~dtr_n;

    genvar gi;
    generate
        for (gi = 0; gi < power_save_config_pkg::POWER_SAVE_CONFIG_LINES; gi++)
        begin : g_line
            // meta stage feeds only the second flop
            always_comb
            begin
                meta_d[gi] = pin_on[gi];
                sync_d[gi] = meta_q[gi];
                prev_d[gi] = sync_q[gi];
                rise_d[gi] = sync_q[gi] & ~prev_q[gi];
            end

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                    rise_q[gi] <= 1'b0;
                end
                else
                begin
                    meta_q[gi] <= meta_d[gi];
                    sync_q[gi] <= sync_d[gi];
                    prev_q[gi] <= prev_d[gi];
                    rise_q[gi] <= rise_d[gi];
                end
            end
        end
    endgenerate

    assign lines.line_on = sync_q;
    assign lines.line_rise = rise_q;

endmodule

// file: rtl/power_save_config_gate.sv
// serial port power-save gating: port enable, idle permission, rx and tx character gating
// assumes a uart receiver and transmitter on sys_clk beside it, modem pins active low
`timescale 1ns/100ps
module power_save_config_gate #(
    parameter int unsigned WAKE_CYC = 32'(power_save_config_pkg::POWER_SAVE_CONFIG_WAKE_CYC),
    parameter int unsigned WINDOW_CYC = 32'(power_save_config_pkg::POWER_SAVE_CONFIG_WINDOW_CYC),
    parameter int unsigned OFF_CYC = 32'(power_save_config_pkg::POWER_SAVE_CONFIG_OFF_CYC),
    parameter int unsigned INACT_CYC = 32'(power_save_config_pkg::POWER_SAVE_CONFIG_INACT_CYC)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] power_save_config,
    input wire logic hw_flow_on_setting,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic net_activity,
    input wire logic if_pending,
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    output logic rx_out_valid,
    output logic [7:0] rx_out_data,
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    output logic tx_in_ready,
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    input wire logic tx_out_ready,
    output logic cts_n,
    output logic port_enabled,
    output logic low_power_idle,
    output logic config_rejected,
    output logic [1:0] active_config
);

    // loads are one short so an expiry lands on the count itself
    localparam logic [31:0] WAKE_LOAD = 32'(WAKE_CYC - 1);
    localparam logic [31:0] WINDOW_LOAD = 32'(WINDOW_CYC - 1);
    localparam logic [31:0] OFF_LOAD = 32'(OFF_CYC - 1);
    localparam logic [31:0] INACT_LOAD = 32'(INACT_CYC - 1);

    power_save_config_line_if lines ();

    power_save_config_line_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .rts_n(rts_n),
        .dtr_n(dtr_n),
        .lines(lines)
    );

    logic rts_on;
    logic ctl_on;
    logic ctl_rise;
    logic req_ok;
    logic timer_done;
    logic rx_accept;

    power_save_config_pkg::power_save_config_state_t state_q;
    power_save_config_pkg::power_save_config_state_t state_d;
    logic [1:0] cfg_q;
    logic [1:0] cfg_d;
    logic [31:0] timer_q;
    logic [31:0] timer_d;

    logic rx_valid_q;
    logic rx_valid_d;
    logic [7:0] rx_data_q;
    logic [7:0] rx_data_d;

    logic tx_full_q;
    logic tx_full_d;
    logic [7:0] tx_data_q;
    logic [7:0] tx_data_d;
    logic tx_gate;
    logic tx_drain;
    logic tx_take;

    logic cts_n_q;
    logic cts_n_d;
    logic port_en_q;
    logic port_en_d;
    logic idle_q;
    logic idle_d;
    logic reject_q;
    logic reject_d;

    // controlling line for the line-driven configurations
    function automatic logic pick_line(input logic [1:0] cfg, input logic [1:0] v);
        if (cfg == power_save_config_pkg::POWER_SAVE_CONFIG_CFG_DTR)
            pick_line = v[power_save_config_pkg::POWER_SAVE_CONFIG_LINE_DTR];
        else
            pick_line = v[power_save_config_pkg::POWER_SAVE_CONFIG_LINE_RTS];
    endfunction

    assign rts_on = lines.line_on[power_save_config_pkg::POWER_SAVE_CONFIG_LINE_RTS];
    assign ctl_on = pick_line(cfg_q, lines.line_on);
    assign ctl_rise = pick_line(cfg_q, lines.line_rise);
    assign timer_done = (timer_q == power_save_config_pkg::POWER_SAVE_CONFIG_TIMER_RESET);
    assign req_ok = !((power_save_config == power_save_config_pkg::POWER_SAVE_CONFIG_CFG_RTS) && hw_flow_on_setting);
    // characters are only taken while the port is fully up
    assign rx_accept = (state_q == power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON);

    // power-save state machine
    always_comb
    begin
        state_d = state_q;
        cfg_d = cfg_q;
        timer_d = timer_done ? timer_q : timer_q - 32'h0000_0001;
        reject_d = !req_ok;
        if (req_ok && (power_save_config != cfg_q))
        begin
            cfg_d = power_save_config;
            timer_d = WINDOW_LOAD;
            if ((power_save_config == power_save_config_pkg::POWER_SAVE_CONFIG_CFG_RTS) || (power_save_config == power_save_config_pkg::POWER_SAVE_CONFIG_CFG_DTR))
                state_d = pick_line(power_save_config, lines.line_on) ? power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON : power_save_config_pkg::POWER_SAVE_CONFIG_ST_OFF;
            else
                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON;
        end
        else if ((cfg_q == power_save_config_pkg::POWER_SAVE_CONFIG_CFG_RTS) && hw_flow_on_setting)
        begin
            // flow control turned on under config 2: fall back to no power saving
            cfg_d = power_save_config_pkg::POWER_SAVE_CONFIG_CFG_OFF;
            state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON;
        end
        else
        begin
            case (cfg_q)
                power_save_config_pkg::POWER_SAVE_CONFIG_CFG_OFF:
                begin
                    state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON;
                end
                power_save_config_pkg::POWER_SAVE_CONFIG_CFG_CYCLIC:
                begin
                    case (state_q)
                        power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON:
                        begin
                            if (rx_in_valid)
                                timer_d = INACT_LOAD;
                            else if (timer_done)
                            begin
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_OFF;
                                timer_d = OFF_LOAD;
                            end
                        end
                        power_save_config_pkg::POWER_SAVE_CONFIG_ST_OFF:
                        begin
                            if (rx_in_valid && !hw_flow_on_setting)
                            begin
                                // wake character itself is dropped
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_WAKE;
                                timer_d = WAKE_LOAD;
                            end
                            else if (timer_done || tx_full_q)
                            begin
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON;
                                timer_d = WINDOW_LOAD;
                            end
                        end
                        default:
                        begin
                            if (timer_done)
                            begin
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON;
                                timer_d = INACT_LOAD;
                            end
                        end
                    endcase
                end
                default:
                begin
                    case (state_q)
                        power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON:
                        begin
                            if (!ctl_on)
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_OFF;
                        end
                        power_save_config_pkg::POWER_SAVE_CONFIG_ST_OFF:
                        begin
                            if (ctl_rise)
                            begin
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_WAKE;
                                timer_d = WAKE_LOAD;
                            end
                        end
                        default:
                        begin
                            if (!ctl_on)
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_OFF;
                            else if (timer_done)
                                state_d = power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON;
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON;
            cfg_q <= power_save_config_pkg::POWER_SAVE_CONFIG_CFG_RESET;
            timer_q <= power_save_config_pkg::POWER_SAVE_CONFIG_TIMER_RESET;
            reject_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            timer_q <= timer_d;
            reject_q <= reject_d;
        end
    end

    // receive gating
    always_comb
    begin
        rx_valid_d = rx_in_valid && rx_accept;
        rx_data_d = rx_in_valid ? rx_in_data : rx_data_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rx_valid_q <= 1'b0;
            rx_data_q <= power_save_config_pkg::POWER_SAVE_CONFIG_DATA_RESET;
        end
        else
        begin
            rx_valid_q <= rx_valid_d;
            rx_data_q <= rx_data_d;
        end
    end

    // transmit holding stage; stalls the source rather than dropping while rts is off with flow control on
    assign tx_gate = !hw_flow_on_setting || rts_on;
    assign tx_drain = tx_full_q && tx_gate && tx_out_ready;
    assign tx_in_ready = !tx_full_q || tx_drain;
    assign tx_take = tx_in_valid && tx_in_ready;

    always_comb
    begin
        tx_full_d = tx_take || (tx_full_q && !tx_drain);
        tx_data_d = tx_take ? tx_in_data : tx_data_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_full_q <= 1'b0;
            tx_data_q <= power_save_config_pkg::POWER_SAVE_CONFIG_DATA_RESET;
        end
        else
        begin
            tx_full_q <= tx_full_d;
            tx_data_q <= tx_data_d;
        end
    end

    // status outputs follow the next state so they line up with the state register
    always_comb
    begin
        cts_n_d = (state_d != power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON);
        // a pending outgoing character keeps the port temporarily up
        port_en_d = (state_d == power_save_config_pkg::POWER_SAVE_CONFIG_ST_ON) || tx_full_d;
        idle_d = (cfg_d != power_save_config_pkg::POWER_SAVE_CONFIG_CFG_OFF) && (state_d == power_save_config_pkg::POWER_SAVE_CONFIG_ST_OFF)
            && !net_activity && !if_pending && !tx_full_d && !rx_in_valid;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cts_n_q <= 1'b0;
            port_en_q <= 1'b1;
            idle_q <= 1'b0;
        end
        else
        begin
            cts_n_q <= cts_n_d;
            port_en_q <= port_en_d;
            idle_q <= idle_d;
        end
    end

    assign rx_out_valid = rx_valid_q;
    assign rx_out_data = rx_data_q;
    assign tx_out_valid = tx_full_q && tx_gate;
    assign tx_out_data = tx_data_q;
    assign cts_n = cts_n_q;
    assign port_enabled = port_en_q;
    assign low_power_idle = idle_q;
    assign config_rejected = reject_q;
    assign active_config = cfg_q;

endmodule

// file: verif/power_save_config_gate_asserts.sv
// concurrent checks on the power-save gating block ports
// assumes bound into power_save_config_gate, single sys_clk domain
`timescale 1ns/100ps
module power_save_config_gate_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] power_save_config,
    input wire logic hw_flow_on_setting,
    input wire logic rts_n,
    input wire logic net_activity,
    input wire logic if_pending,
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    input wire logic rx_out_valid,
    input wire logic [7:0] rx_out_data,
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_ready,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_ready,
    input wire logic cts_n,
    input wire logic port_enabled,
    input wire logic low_power_idle,
    input wire logic config_rejected,
    input wire logic [1:0] active_config
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_cfg0_rx;
        rx_in_valid && active_config == 2'h0 |=> rx_out_valid && rx_out_data == $past(rx_in_data);
    endproperty
    a_cfg0_rx: assert property (p_cfg0_rx) else $error("char lost in config 0");

    property p_rx_drop;
        rx_in_valid && cts_n |=> !rx_out_valid;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("char taken on disabled port");

    property p_cts_port;
        !cts_n |-> port_enabled;
    endproperty
    a_cts_port: assert property (p_cts_port) else $error("cts on with port disabled");

    property p_reject;
        power_save_config == 2'h2 && hw_flow_on_setting |=> config_rejected && active_config != 2'h2;
    endproperty
    a_reject: assert property (p_reject) else $error("config 2 with flow on taken");

    property p_cfg_take;
        power_save_config != active_config && !(power_save_config == 2'h2 && hw_flow_on_setting)
            && !(active_config == 2'h2 && hw_flow_on_setting) |=> active_config == $past(power_save_config);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("config request not applied");

    property p_tx_gate;
        hw_flow_on_setting && rts_n && $past(rts_n) && $past(rts_n, 2) && $past(rts_n, 3) |-> !tx_out_valid;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("char sent while rts off");

    property p_tx_hold;
        tx_out_valid && !tx_out_ready |-> !tx_in_ready ##1 $stable(tx_out_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("held char overwritten");

    property p_tx_flow_off;
        (tx_in_valid && tx_in_ready && !hw_flow_on_setting) ##1 !hw_flow_on_setting
            |-> tx_out_valid && tx_out_data == $past(tx_in_data);
    endproperty
    a_tx_flow_off: assert property (p_tx_flow_off) else $error("char held with flow off");

    property p_idle_block;
        net_activity || if_pending |=> !low_power_idle;
    endproperty
    a_idle_block: assert property (p_idle_block) else $error("idle despite activity");

    property p_idle_cfg0;
        active_config == 2'h0 && $past(active_config) == 2'h0 |-> !low_power_idle;
    endproperty
    a_idle_cfg0: assert property (p_idle_cfg0) else $error("idle in config 0");
endmodule

bind power_save_config_gate power_save_config_gate_asserts u_chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .power_save_config(power_save_config),
    .hw_flow_on_setting(hw_flow_on_setting),
    .rts_n(rts_n),
    .net_activity(net_activity),
    .if_pending(if_pending),
    .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data),
    .rx_out_valid(rx_out_valid),
    .rx_out_data(rx_out_data),
    .tx_in_valid(tx_in_valid),
    .tx_in_data(tx_in_data),
    .tx_in_ready(tx_in_ready),
    .tx_out_valid(tx_out_valid),
    .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready),
    .cts_n(cts_n),
    .port_enabled(port_enabled),
    .low_power_idle(low_power_idle),
    .config_rejected(config_rejected),
    .active_config(active_config)
);

// file: verif/power_save_config_host_model.sv
// host terminal on the far side of the serial port
// assumes calls start just after a rising edge
`timescale 1ns/100ps
module power_save_config_host_model (
    input wire logic sys_clk,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    output logic tx_out_ready,
    output logic rts_n,
    output logic dtr_n,
    output logic rx_in_valid,
    output logic [7:0] rx_in_data
);
    logic [7:0] got[$];
    initial
    begin
        tx_out_ready = 1'b1;
        rts_n = 1'b1;
        dtr_n = 1'b1;
        rx_in_valid = 1'b0;
        rx_in_data = 8'h00;
    end
    always @(posedge sys_clk)
    begin
        if (tx_out_valid && tx_out_ready)
            got.push_back(tx_out_data);
    end
    task automatic lines(input logic rts_on, input logic dtr_on);
        rts_n = !rts_on;
        dtr_n = !dtr_on;
    endtask
    task automatic set_ready(input logic r);
        tx_out_ready = r;
    endtask
    // under flow control callers send with cts low except the config 3 drop check; after a wake char they wait for cts
    task automatic send(input logic [7:0] d);
        rx_in_valid = 1'b1;
        rx_in_data = d;
        @(posedge sys_clk);
        #1;
        rx_in_valid = 1'b0;
        rx_in_data = ~d;
    endtask
endmodule

// file: verif/uart_power_save_gating_tb.sv
// self-checking bench for the power-save gating block
// assumes short sim timers: wake 20, window 10, off 30, inactivity 50
`timescale 1ns/100ps
module uart_power_save_gating_tb;
    logic sys_clk, rst, hw_flow_on_setting, net_activity, if_pending, tx_in_valid;
    logic [1:0] power_save_config;
    logic [7:0] tx_in_data;
    logic rts_n, dtr_n, rx_in_valid, rx_out_valid, tx_in_ready, tx_out_valid, tx_out_ready;
    logic cts_n, port_enabled, low_power_idle, config_rejected;
    logic [7:0] rx_in_data, rx_out_data, tx_out_data;
    logic [1:0] active_config;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    power_save_config_gate #(.WAKE_CYC(20), .WINDOW_CYC(10), .OFF_CYC(30), .INACT_CYC(50)) u_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .power_save_config(power_save_config),
        .hw_flow_on_setting(hw_flow_on_setting),
        .rts_n(rts_n),
        .dtr_n(dtr_n),
        .net_activity(net_activity),
        .if_pending(if_pending),
        .rx_in_valid(rx_in_valid),
        .rx_in_data(rx_in_data),
        .rx_out_valid(rx_out_valid),
        .rx_out_data(rx_out_data),
        .tx_in_valid(tx_in_valid),
        .tx_in_data(tx_in_data),
        .tx_in_ready(tx_in_ready),
        .tx_out_valid(tx_out_valid),
        .tx_out_data(tx_out_data),
        .tx_out_ready(tx_out_ready),
        .cts_n(cts_n),
        .port_enabled(port_enabled),
        .low_power_idle(low_power_idle),
        .config_rejected(config_rejected),
        .active_config(active_config)
    );
    power_save_config_host_model u_host (
        .sys_clk(sys_clk),
        .tx_out_valid(tx_out_valid),
        .tx_out_data(tx_out_data),
        .tx_out_ready(tx_out_ready),
        .rts_n(rts_n),
        .dtr_n(dtr_n),
        .rx_in_valid(rx_in_valid),
        .rx_in_data(rx_in_data)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, well above the few hundred cycles of the run
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cfg(input logic [1:0] c, input logic f);
        power_save_config = c;
        hw_flow_on_setting = f;
        cyc(2);
    endtask
    task automatic wait_cts(input logic v, input int max);
        int i;
        i = 0;
        while (cts_n !== v && i < max)
        begin
            cyc(1);
            i++;
        end
        check(cts_n, v);
    endtask
    task automatic push(input logic [7:0] d);
        tx_in_valid = 1'b1;
        tx_in_data = d;
        while (tx_in_ready !== 1'b1)
            cyc(1);
        cyc(1);
        tx_in_valid = 1'b0;
    endtask
    task automatic rx_chk(input logic [7:0] d, input logic ok);
        u_host.send(d);
        check(rx_out_valid, ok);
        if (ok)
            check(rx_out_data, d);
    endtask

    task automatic t_reset();
        check(active_config, 2'h0);
        check(cts_n, 1'b0);
        check(port_enabled, 1'b1);
        check(low_power_idle, 1'b0);
    endtask
    task automatic t_cfg0();
        cfg(2'h0, 1'b1);
        u_host.lines(1'b0, 1'b0);
        cyc(4);
        for (int i = 0; i < 4; i++)
        begin
            rx_chk(8'ha0 + 8'(i), 1'b1);
            // strobe must fall for a cycle, never set twice in one step
            cyc(1);
        end
    endtask
    task automatic t_flow();
        push(8'h5a);
        cyc(5);
        check(tx_out_valid, 1'b0);
        check(tx_in_ready, 1'b0);
        check(u_host.got.size(), 0);
        u_host.lines(1'b1, 1'b0);
        cyc(6);
        check(u_host.got.size(), 1);
        check(u_host.got[0], 8'h5a);
        cfg(2'h0, 1'b0);
        u_host.lines(1'b0, 1'b0);
        u_host.set_ready(1'b0);
        cyc(4);
        push(8'h3c);
        cyc(3);
        check(tx_out_valid, 1'b1);
        u_host.set_ready(1'b1);
        cyc(2);
        check(u_host.got[$], 8'h3c);
    endtask
    task automatic t_cfg2();
        cfg(2'h2, 1'b1);
        check(config_rejected, 1'b1);
        check(active_config, 2'h0);
        cfg(2'h2, 1'b0);
        check(active_config, 2'h2);
        cyc(6);
        check(cts_n, 1'b1);
        check(port_enabled, 1'b0);
        check(low_power_idle, 1'b1);
        if_pending = 1'b1;
        cyc(1);
        check(low_power_idle, 1'b0);
        if_pending = 1'b0;
        net_activity = 1'b1;
        cyc(1);
        check(low_power_idle, 1'b0);
        net_activity = 1'b0;
        rx_chk(8'h11, 1'b0);
        u_host.lines(1'b1, 1'b0);
        cyc(8);
        check(cts_n, 1'b1);
        wait_cts(1'b0, 40);
        check(port_enabled, 1'b1);
        check(low_power_idle, 1'b0);
        rx_chk(8'h22, 1'b1);
    endtask
    task automatic t_cfg3();
        cfg(2'h3, 1'b1);
        cyc(4);
        check(cts_n, 1'b1);
        rx_chk(8'h66, 1'b0);
        push(8'h77);
        cyc(2);
        check(u_host.got[$], 8'h77);
        u_host.lines(1'b1, 1'b1);
        wait_cts(1'b0, 40);
        rx_chk(8'h55, 1'b1);
    endtask
    task automatic t_cfg1();
        cfg(2'h1, 1'b0);
        wait_cts(1'b1, 20);
        rx_chk(8'h33, 1'b0);
        cyc(10);
        check(cts_n, 1'b1);
        wait_cts(1'b0, 20);
        cyc(30);
        rx_chk(8'h44, 1'b1);
        cyc(40);
        check(cts_n, 1'b0);
        wait_cts(1'b1, 20);
        wait_cts(1'b0, 40);
        // flow on: host keeps its character until cts shows the port up
        cfg(2'h1, 1'b1);
        wait_cts(1'b1, 20);
        wait_cts(1'b0, 40);
        rx_chk(8'h88, 1'b1);
    endtask

    initial
    begin
        rst = 1'b1;
        power_save_config = 2'h0;
        hw_flow_on_setting = 1'b0;
        net_activity = 1'b0;
        if_pending = 1'b0;
        tx_in_valid = 1'b0;
        tx_in_data = 8'h00;
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        cyc(1);
        t_reset();
        t_cfg0();
        t_flow();
        t_cfg2();
        t_cfg3();
        t_cfg1();
        test_done();
    end
endmodule
